// ---- src/gpp_pkg.sv ----
package gpp_pkg;

   // port geometry: four ports of up to eight pins each
   localparam int GPP_NPORT = 4;
   localparam int GPP_PW    = 8;
   localparam int GPP_NPIN  = GPP_NPORT * GPP_PW;
   localparam int GPP_NPERI = 3;

   // implemented pins: ports 0 and 1 full, port 2 one pin, port 3 three pins (20 in all)
   localparam logic [31:0] GPP_IMPL_MASK = 32'h0701ffff;
   localparam int          GPP_MAX_PINS  = 20;

   // values after reset
   localparam logic        GPP_DOUT_RST  = 1'b0;
   localparam logic        GPP_PEND_RST  = 1'b0;
   localparam logic        GPP_PAD_RST   = 1'b0;

   // drive modes, three-bit field
   typedef enum logic [2:0] {
      GPP_DM_ANALOG,
      GPP_DM_INPUT,
      GPP_DM_WPU_SPD,
      GPP_DM_SPU_WPD,
      GPP_DM_OD_LO,
      GPP_DM_OD_HI,
      GPP_DM_STRONG,
      GPP_DM_WEAK
   } gpp_dm_t;

   // signal matrix selection per pin
   typedef enum logic [1:0] {
      GPP_SEL_DATA,
      GPP_SEL_PERI0,
      GPP_SEL_PERI1,
      GPP_SEL_PERI2
   } gpp_sel_t;

   // pin interrupt event selection
   typedef enum logic [1:0] {
      GPP_IRQ_OFF,
      GPP_IRQ_RISE,
      GPP_IRQ_FALL,
      GPP_IRQ_BOTH
   } gpp_irq_t;

endpackage

// ---- src/gpp_pin.sv ----
`timescale 1ns/100ps
`default_nettype none

module gpp_pin
   import gpp_pkg::*;
(
   input  wire logic    ref_clk,
   input  wire logic    srst,
   input  wire logic    ce,
   input  wire gpp_dm_t mode,
   input  wire logic    ibuf_en,
   input  wire logic    obuf_en,
   input  wire logic    dout,
   input  wire logic    slew_slow,
   input  wire logic    thr_lvttl,
   input  wire logic    pad_in,
   output logic         pad_out_r,
   output logic         pad_oe_r,
   output logic         pad_pu_r,
   output logic         pad_pd_r,
   output logic         pad_ie_r,
   output logic         pad_slow_r,
   output logic         pad_lvttl_r,
   output logic         state_r
);

   logic out_act;
   logic out_nxt;
   logic oe_nxt;
   logic pu_nxt;
   logic pd_nxt;
   logic ie_nxt;

   // decode of drive mode into strong and weak drivers
   always_comb begin
      out_act = obuf_en && (mode != GPP_DM_ANALOG) && (mode != GPP_DM_INPUT);
      ie_nxt  = ibuf_en && (mode != GPP_DM_ANALOG);
      out_nxt = 1'b0;
      oe_nxt  = 1'b0;
      pu_nxt  = 1'b0;
      pd_nxt  = 1'b0;
      case (mode)
         GPP_DM_WPU_SPD: begin
            oe_nxt = out_act && !dout;
            pu_nxt = out_act && dout;
         end
         GPP_DM_SPU_WPD: begin
            out_nxt = 1'b1;
            oe_nxt  = out_act && dout;
            pd_nxt  = out_act && !dout;
         end
         GPP_DM_OD_LO: begin
            oe_nxt = out_act && !dout;
         end
         GPP_DM_OD_HI: begin
            out_nxt = 1'b1;
            oe_nxt  = out_act && dout;
         end
         GPP_DM_STRONG: begin
            out_nxt = dout;
            oe_nxt  = out_act;
         end
         GPP_DM_WEAK: begin
            pu_nxt = out_act && dout;
            pd_nxt = out_act && !dout;
         end
         default: begin
            oe_nxt = 1'b0;
         end
      endcase
   end

   // pad controls; reset forces every buffer off
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pad_out_r   <= GPP_PAD_RST;
         pad_oe_r    <= GPP_PAD_RST;
         pad_pu_r    <= GPP_PAD_RST;
         pad_pd_r    <= GPP_PAD_RST;
         pad_ie_r    <= GPP_PAD_RST;
         pad_slow_r  <= GPP_PAD_RST;
         pad_lvttl_r <= GPP_PAD_RST;
      end else if (ce) begin
         pad_out_r   <= out_nxt;
         pad_oe_r    <= oe_nxt;
         pad_pu_r    <= pu_nxt;
         pad_pd_r    <= pd_nxt;
         pad_ie_r    <= ie_nxt;
         pad_slow_r  <= slew_slow;
         pad_lvttl_r <= thr_lvttl;
      end
   end

   // sensed level; a disabled input buffer reads low
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_r <= GPP_PAD_RST;
      end else if (ce) begin
         state_r <= pad_ie_r && pad_in;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   property p_analog_off;
      ce && (mode == GPP_DM_ANALOG) |=> !pad_oe_r && !pad_pu_r && !pad_pd_r && !pad_ie_r;
   endproperty
   a_analog_off: assert property (p_analog_off) else $error("analog mode left a buffer on");

   property p_obuf_off;
      ce && !obuf_en |=> !pad_oe_r && !pad_pu_r && !pad_pd_r;
   endproperty
   a_obuf_off: assert property (p_obuf_off) else $error("output drives with buffer disabled");

   property p_od_lo;
      ce && (mode == GPP_DM_OD_LO) |=> !(pad_oe_r && pad_out_r);
   endproperty
   a_od_lo: assert property (p_od_lo) else $error("open drain low drove high");

   property p_strong;
      ce && (mode == GPP_DM_STRONG) && obuf_en |=> pad_oe_r && (pad_out_r == $past(dout));
   endproperty
   a_strong: assert property (p_strong) else $error("strong mode not driving data");

   property p_ibuf_gate;
      ce && !pad_ie_r |=> !state_r;
   endproperty
   a_ibuf_gate: assert property (p_ibuf_gate) else $error("state seen with input disabled");

   property p_thr_slew;
      ce |=> (pad_lvttl_r == $past(thr_lvttl)) && (pad_slow_r == $past(slew_slow));
   endproperty
   a_thr_slew: assert property (p_thr_slew) else $error("threshold or slew not applied");

endmodule

`default_nettype wire

// ---- src/gpp_port.sv ----
`timescale 1ns/100ps
`default_nettype none

// Function
// - each pin offers eight drive modes, analog through weak/strong/open-drain mixes
// - input threshold per pin selects CMOS or LVTTL levels
// - input and output buffers enable independently of each other; analog mode turns both off, input mode the output
// - output slew rate per pin is software selectable
// - pins group into eight-bit ports; ports 2 and 3 have fewer pins
// - no more than 20 general-purpose pins in total
// - during reset every pin buffer is held disabled
// - each port has output-data register and pin-state register
// - enabled pins raise interrupts, merged into one request per port, four total
// - a matrix picks port data or a peripheral signal per pin
// - every implemented pin works as plain general-purpose input/output
module gpp_port
   import gpp_pkg::*;
#(
   parameter logic [GPP_NPIN-1:0] IMPL_MASK = GPP_IMPL_MASK
)
(
   input  wire logic                         ref_clk,
   input  wire logic                         srst,
   input  wire logic                         ce,
   input  wire logic [3*GPP_NPIN-1:0]        drive_mode,
   input  wire logic [GPP_NPIN-1:0]          ibuf_en,
   input  wire logic [GPP_NPIN-1:0]          obuf_en,
   input  wire logic [GPP_NPIN-1:0]          slew_slow,
   input  wire logic [GPP_NPIN-1:0]          thr_lvttl,
   input  wire logic [2*GPP_NPIN-1:0]        mux_sel,
   input  wire logic [GPP_NPERI*GPP_NPIN-1:0] peri_out,
   input  wire logic [2*GPP_NPIN-1:0]        irq_cfg,
   input  wire logic                         dout_we,
   input  wire logic [GPP_NPIN-1:0]          dout_wdata,
   input  wire logic                         pend_clr_we,
   input  wire logic [GPP_NPIN-1:0]          pend_clr_wdata,
   input  wire logic [GPP_NPIN-1:0]          pad_in,
   output logic      [GPP_NPIN-1:0]          pad_out_r,
   output logic      [GPP_NPIN-1:0]          pad_oe_r,
   output logic      [GPP_NPIN-1:0]          pad_pu_r,
   output logic      [GPP_NPIN-1:0]          pad_pd_r,
   output logic      [GPP_NPIN-1:0]          pad_ie_r,
   output logic      [GPP_NPIN-1:0]          pad_slow_r,
   output logic      [GPP_NPIN-1:0]          pad_lvttl_r,
   output logic      [GPP_NPIN-1:0]          dout_r,
   output logic      [GPP_NPIN-1:0]          pin_state_r,
   output logic      [GPP_NPIN-1:0]          pend_r,
   output logic      [GPP_NPORT-1:0]         port_irq_r
);

   logic [GPP_NPIN-1:0]  state_prev_r;
   logic [GPP_NPIN-1:0]  pin_evt;
   logic [GPP_NPIN-1:0]  irq_on;
   logic [GPP_NPIN-1:0]  pin_drv;
   logic [GPP_NPIN-1:0]  pend_nxt;
   logic [GPP_NPORT-1:0] port_any;

   // output-data register, unimplemented bits stay zero
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dout_r <= {GPP_NPIN{GPP_DOUT_RST}};
      end else if (ce && dout_we) begin
         dout_r <= dout_wdata & IMPL_MASK;
      end
   end

   // per-pin cells: matrix, drive decode and sensing
   genvar gi;
   generate
      for (gi = 0; gi < GPP_NPIN; gi++) begin : g_pin
         gpp_dm_t  dm;
         gpp_sel_t sel;
         gpp_irq_t icfg;

         // unimplemented pins are pinned to analog, so they never drive
         assign dm   = IMPL_MASK[gi] ? gpp_dm_t'(drive_mode[3*gi +: 3]) : GPP_DM_ANALOG;
         assign sel  = gpp_sel_t'(mux_sel[2*gi +: 2]);
         assign icfg = gpp_irq_t'(irq_cfg[2*gi +: 2]);

         // signal matrix: plain data or one of the peripheral signals
         always_comb begin
            case (sel)
               GPP_SEL_DATA:  pin_drv[gi] = dout_r[gi];
               GPP_SEL_PERI0: pin_drv[gi] = peri_out[GPP_NPERI*gi];
               GPP_SEL_PERI1: pin_drv[gi] = peri_out[GPP_NPERI*gi + 1];
               GPP_SEL_PERI2: pin_drv[gi] = peri_out[GPP_NPERI*gi + 2];
               default:       pin_drv[gi] = dout_r[gi];
            endcase
         end

         // event detection on the sensed level
         always_comb begin
            irq_on[gi] = IMPL_MASK[gi] && (icfg != GPP_IRQ_OFF);
            case (icfg)
               GPP_IRQ_RISE: pin_evt[gi] = pin_state_r[gi] && !state_prev_r[gi];
               GPP_IRQ_FALL: pin_evt[gi] = !pin_state_r[gi] && state_prev_r[gi];
               GPP_IRQ_BOTH: pin_evt[gi] = pin_state_r[gi] != state_prev_r[gi];
               default:      pin_evt[gi] = 1'b0;
            endcase
            if (!IMPL_MASK[gi]) begin
               pin_evt[gi] = 1'b0;
            end
         end

         gpp_pin u_pin (
            .ref_clk     (ref_clk),
            .srst        (srst),
            .ce          (ce),
            .mode        (dm),
            .ibuf_en     (ibuf_en[gi]),
            .obuf_en     (obuf_en[gi]),
            .dout        (pin_drv[gi]),
            .slew_slow   (slew_slow[gi]),
            .thr_lvttl   (thr_lvttl[gi]),
            .pad_in      (pad_in[gi]),
            .pad_out_r   (pad_out_r[gi]),
            .pad_oe_r    (pad_oe_r[gi]),
            .pad_pu_r    (pad_pu_r[gi]),
            .pad_pd_r    (pad_pd_r[gi]),
            .pad_ie_r    (pad_ie_r[gi]),
            .pad_slow_r  (pad_slow_r[gi]),
            .pad_lvttl_r (pad_lvttl_r[gi]),
            .state_r     (pin_state_r[gi])
         );
      end
   endgenerate

   // previous level, for edge detection
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_prev_r <= '0;
      end else if (ce) begin
         state_prev_r <= pin_state_r;
      end
   end

   // pending flags: a new event beats a same-cycle clear
   always_comb begin
      pend_nxt = pend_r;
      if (pend_clr_we) begin
         pend_nxt = pend_nxt & ~pend_clr_wdata;
      end
      pend_nxt = pend_nxt | pin_evt;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pend_r <= {GPP_NPIN{GPP_PEND_RST}};
      end else if (ce) begin
         pend_r <= pend_nxt;
      end
   end

   // one request per port while any enabled flag is pending
   genvar gp;
   generate
      for (gp = 0; gp < GPP_NPORT; gp++) begin : g_port
         assign port_any[gp] = |(pend_nxt[GPP_PW*gp +: GPP_PW] & irq_on[GPP_PW*gp +: GPP_PW]);
      end
   endgenerate

   // registered so the request line is glitch free toward the interrupt controller
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         port_irq_r <= '0;
      end else if (ce) begin
         port_irq_r <= port_any;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence s_reset_seen;
      srst;
   endsequence

   sequence s_all_off;
      (pad_oe_r == '0) && (pad_pu_r == '0) && (pad_pd_r == '0) && (pad_ie_r == '0);
   endsequence

   property p_reset_off;
      disable iff (1'b0) s_reset_seen |=> s_all_off;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("buffers not disabled by reset");

   property p_unimpl_quiet;
      ((pad_oe_r | pad_pu_r | pad_pd_r | pad_ie_r) & ~IMPL_MASK) == '0;
   endproperty
   a_unimpl_quiet: assert property (p_unimpl_quiet) else $error("unimplemented pin active");

   property p_dout_write;
      ce && dout_we |=> dout_r == ($past(dout_wdata) & IMPL_MASK);
   endproperty
   a_dout_write: assert property (p_dout_write) else $error("output data not stored");

   sequence s_evt;
      ce && (pin_evt != '0);
   endsequence

   property p_evt_sets;
      s_evt |=> ((pend_r & $past(pin_evt)) == $past(pin_evt));
   endproperty
   a_evt_sets: assert property (p_evt_sets) else $error("event did not set pending");

   property p_clr_w1c;
      ce && pend_clr_we |=> (pend_r & $past(pend_clr_wdata) & ~$past(pin_evt)) == '0;
   endproperty
   a_clr_w1c: assert property (p_clr_w1c) else $error("write one did not clear pending");

   // a flag held with no clear in the same cycle keeps the request up on the next edge
   property p_port0_irq;
      ce && ((pend_r[GPP_PW-1:0] & irq_on[GPP_PW-1:0]) != '0) && !pend_clr_we
         |=> port_irq_r[0];
   endproperty
   a_port0_irq: assert property (p_port0_irq) else $error("port 0 request missing");

   property p_irq_quiet;
      ce && (port_any == '0) |=> port_irq_r == '0;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("request with nothing pending");

   property p_freeze;
      !ce |=> $stable(pend_r) && $stable(dout_r) && $stable(pad_oe_r);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

endmodule

`default_nettype wire

// ---- verif/gpp_pin_board.sv ----
`timescale 1ns/100ps
`default_nettype none

// board side of the pins: an outside driver wins, then the device's own drive, then its pulls
module gpp_pin_board
   import gpp_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic [GPP_NPIN-1:0] ext_en,
   input  wire logic [GPP_NPIN-1:0] ext_val,
   input  wire logic [GPP_NPIN-1:0] pad_out_r,
   input  wire logic [GPP_NPIN-1:0] pad_oe_r,
   input  wire logic [GPP_NPIN-1:0] pad_pu_r,
   input  wire logic [GPP_NPIN-1:0] pad_pd_r,
   output logic      [GPP_NPIN-1:0] pad_in
);
   logic [GPP_NPIN-1:0] float_r = '0;

   // a floating line toggles each cycle so no steady level can be trusted
   always_ff @(posedge ref_clk) begin
      float_r <= ~float_r;
   end

   // resolve each line; contention is not modelled
   always_comb begin
      for (int i = 0; i < GPP_NPIN; i++) begin
         if (ext_en[i]) begin
            pad_in[i] = ext_val[i];
         end else if (pad_oe_r[i]) begin
            pad_in[i] = pad_out_r[i];
         end else if (pad_pu_r[i] || pad_pd_r[i]) begin
            pad_in[i] = pad_pu_r[i];
         end else begin
            pad_in[i] = float_r[i];
         end
      end
   end
endmodule

`default_nettype wire

// ---- verif/test_gpp_port.sv ----
`timescale 1ns/100ps
`default_nettype none

module test_gpp_port;
   import gpp_pkg::*;
   localparam logic [31:0] M = GPP_IMPL_MASK;
   localparam logic [31:0] ALL = 32'hffffffff;
   typedef struct {int k; logic [31:0] e; logic [31:0] m; longint t;} gpp_note_t;
   logic        ref_clk, srst, ce, dout_we, pend_clr_we;
   logic [95:0] drive_mode, peri_out;
   logic [63:0] mux_sel, irq_cfg;
   logic [31:0] ibuf_en, obuf_en, slew_slow, thr_lvttl, dout_wdata, pend_clr_wdata;
   logic [31:0] ext_en, ext_val, pad_in, pad_out_r, pad_oe_r, pad_pu_r, pad_pd_r;
   logic [31:0] pad_ie_r, pad_slow_r, pad_lvttl_r, dout_r, pin_state_r, pend_r, r, f;
   logic [3:0]  port_irq_r;
   logic [31:0] seed = 32'h000158fa;
   logic [31:0] dexp = 32'h00000000;
   gpp_note_t   q[$];
   int          n_mismatch = 0;
   int          checks = 0;

   gpp_port gpp_port_i (.ref_clk, .srst, .ce, .drive_mode, .ibuf_en, .obuf_en, .slew_slow, .thr_lvttl,
      .mux_sel, .peri_out, .irq_cfg, .dout_we, .dout_wdata, .pend_clr_we, .pend_clr_wdata, .pad_in,
      .pad_out_r, .pad_oe_r, .pad_pu_r, .pad_pd_r, .pad_ie_r, .pad_slow_r, .pad_lvttl_r, .dout_r,
      .pin_state_r, .pend_r, .port_irq_r);
   gpp_pin_board gpp_pin_board_i (.ref_clk, .ext_en, .ext_val, .pad_out_r, .pad_oe_r, .pad_pu_r,
      .pad_pd_r, .pad_in);

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [31:0] seen(input int k);
      case (k)
         0: return pad_oe_r;
         1: return pad_out_r & pad_oe_r;
         2: return pad_pu_r;
         3: return pad_pd_r;
         4: return pad_ie_r;
         5: return pad_slow_r;
         6: return pad_lvttl_r;
         7: return dout_r;
         8: return pin_state_r;
         9: return pend_r;
         default: return {28'h0, port_irq_r};
      endcase
   endfunction

   task automatic check(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask

   // called one step after a driving edge; n is the latency in cycles
   task automatic note(input int k, input logic [31:0] e, input logic [31:0] m, input int n);
      q.push_back('{k, e & m, m, $time + 8 * n + 3});
   endtask

   // results are judged at the falling edge, well clear of the updates
   always @(negedge ref_clk) begin
      while (q.size() > 0 && q[0].t <= $time) begin
         check(seen(q[0].k) & q[0].m, q[0].e);
         void'(q.pop_front());
      end
   end

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   task automatic print_verdict();
      // a note never judged counts against the run
      n_mismatch += q.size();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // random setup on every pin, applied back to back; fm forces one mode code everywhere
   task automatic cfg(input bit fm, input logic [2:0] m);
      logic [31:0] oe, pu, pd, d, ie;
      logic [1:0]  s;
      @(posedge ref_clk);
      dout_we <= 1'b0;
      drive_mode <= fm ? {32{m}} : {rnd(), rnd(), rnd()};
      {obuf_en, ibuf_en, slew_slow, thr_lvttl} <= {rnd(), rnd(), rnd(), rnd()};
      {mux_sel, peri_out} <= {rnd(), rnd(), rnd(), rnd(), rnd()};
      #1;
      {oe, pu, pd} = '0;
      for (int i = 0; i < 32; i++) begin
         s = mux_sel[2*i +: 2];
         d[i] = (s == 2'h0) ? dexp[i] : peri_out[3*i + s - 1];
         case (gpp_dm_t'(drive_mode[3*i +: 3]))
            GPP_DM_WPU_SPD: {pu[i], oe[i]} = {d[i], ~d[i]};
            GPP_DM_SPU_WPD: {oe[i], pd[i]} = {d[i], ~d[i]};
            GPP_DM_OD_LO:   oe[i] = ~d[i];
            GPP_DM_OD_HI:   oe[i] = d[i];
            GPP_DM_STRONG:  oe[i] = 1'b1;
            GPP_DM_WEAK:    {pu[i], pd[i]} = {d[i], ~d[i]};
            default:        oe[i] = 1'b0;
         endcase
         ie[i] = ibuf_en[i] && drive_mode[3*i +: 3] != 3'h0;
      end
      note(0, oe & obuf_en & M, ALL, 1);
      note(1, d, oe & obuf_en & M, 1);
      note(2, pu & obuf_en & M, ALL, 1);
      note(3, pd & obuf_en & M, ALL, 1);
      note(4, ie & M, ALL, 1);
      // slew and threshold pass through on every cell, implemented or not
      note(5, slew_slow, ALL, 1);
      note(6, thr_lvttl, ALL, 1);
   endtask

   // the whole run is under 160 cycles; this bound is more than fifteen times that
   initial begin
      #20000;
      n_mismatch++;
      print_verdict();
   end

   initial begin
      {srst, ce, dout_we, pend_clr_we} = 4'hf;
      {obuf_en, ibuf_en, dout_wdata} = {ALL, ALL, ALL};
      drive_mode = {32{GPP_DM_STRONG}};
      {ext_en, ext_val, slew_slow, thr_lvttl, pend_clr_wdata} = '0;
      {mux_sel, irq_cfg, peri_out} = '0;
      // live setup and writes must not reach the pins under reset
      repeat (2) @(posedge ref_clk);
      #1;
      for (int k = 0; k < 11; k++) note(k, 32'h0, ALL, 1);
      @(posedge ref_clk);
      {srst, dout_we, pend_clr_we} <= 3'h0;
      done("reset");
      @(posedge ref_clk);
      dout_we <= 1'b1;
      dout_wdata <= rnd();
      #1;
      dexp = dout_wdata & M;
      note(7, dexp, ALL, 1);
      for (int m = 0; m < 8; m++) cfg(1'b1, m[2:0]);
      repeat (30) cfg(1'b0, 3'h0);
      done("drive modes");
      // reset in mid-run clears the data register and drops all drive
      @(posedge ref_clk);
      srst <= 1'b1;
      #1;
      dexp = 32'h0;
      for (int k = 0; k < 11; k++) note(k, 32'h0, ALL, 1);
      @(posedge ref_clk);
      srst <= 1'b0;
      cfg(1'b0, 3'h0);
      done("mid reset");
      repeat (12) begin
         @(posedge ref_clk);
         drive_mode <= {32{GPP_DM_INPUT}};
         {ibuf_en, ext_en, ext_val} <= {rnd(), ALL, rnd()};
         #1;
         note(8, ibuf_en & ext_val & M, ALL, 2);
         @(posedge ref_clk);
      end
      done("pin state");
      for (int c = 0; c < 4; c++) begin
         @(posedge ref_clk);
         irq_cfg <= {32{c[1:0]}};
         {ibuf_en, ext_val} <= {ALL, 32'h0};
         repeat (3) @(posedge ref_clk);
         {pend_clr_we, pend_clr_wdata} <= {1'b1, ALL};
         #1;
         note(9, 32'h0, ALL, 1);
         @(posedge ref_clk);
         {pend_clr_we, ext_val} <= {1'b0, ALL};
         #1;
         r = (c == 1 || c == 3) ? M : 32'h0;
         note(9, r, ALL, 2);
         note(10, {28'h0, {4{r != 0}}}, ALL, 2);
         repeat (2) @(posedge ref_clk);
         {pend_clr_we, pend_clr_wdata} <= {1'b1, 32'h000000ff};
         #1;
         note(9, r & ~32'h000000ff, ALL, 1);
         note(10, {28'h0, (r != 0) ? 4'he : 4'h0}, ALL, 1);
         @(posedge ref_clk);
         {pend_clr_we, ext_val} <= {1'b0, 32'h0};
         // clear lands on the edge of the falling event: the event must win
         @(posedge ref_clk);
         {pend_clr_we, pend_clr_wdata} <= {1'b1, ALL};
         #1;
         f = (c >= 2) ? M : 32'h0;
         note(9, f, ALL, 1);
         note(10, {28'h0, {4{f != 0}}}, ALL, 1);
         @(posedge ref_clk);
         pend_clr_we <= 1'b0;
      end
      done("interrupts");
      // clock enable low: writes, clears and new setup must all wait
      @(posedge ref_clk);
      {ce, dout_we, pend_clr_we} <= 3'h3;
      {dout_wdata, pend_clr_wdata, ibuf_en} <= {ALL, ALL, 32'h0};
      #1;
      for (int n = 1; n < 4; n++) begin
         note(4, M, ALL, n);
         note(7, 32'h0, ALL, n);
         note(9, M, ALL, n);
         note(10, 32'hf, ALL, n);
      end
      repeat (3) @(posedge ref_clk);
      {ce, pend_clr_we} <= 2'h2;
      #1;
      note(4, 32'h0, ALL, 1);
      note(7, M, ALL, 1);
      note(9, M, ALL, 1);
      @(posedge ref_clk);
      dout_we <= 1'b0;
      done("clock enable");
      repeat (3) @(posedge ref_clk);
      print_verdict();
   end
endmodule

`default_nettype wire
